//--- atc_consts.svh
// Register offsets, field positions and reset values of the timer control block
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

`define ATC_A_CR1 8'h00
`define ATC_A_EN 8'h04
`define ATC_A_STAT 8'h08
`define ATC_A_MASK 8'h0c
`define ATC_A_ARR 8'h10
`define ATC_A_CNT 8'h14
`define ATC_A_CHSEL 8'h18
`define ATC_A_CCR0 8'h20

`define ATC_CR1_CEN 0
`define ATC_CR1_DIR 4
`define ATC_CR1_CMS_LO 5
`define ATC_CR1_CMS_HI 6
`define ATC_CR1_RELOAD_PRELOAD_ENABLE 7
`define ATC_CR1_CKD_LO 8
`define ATC_CR1_CKD_HI 9
`define ATC_CR1_REMAP 11
`define ATC_CR1_W 12
`define ATC_CR1_WMASK 12'hbff
`define ATC_CR1_RST 12'h000

`define ATC_EN_RST 1'h0
`define ATC_CNT_FLAG 31
`define ATC_ST_UPD 0
`define ATC_CH_OUT 2'h0

`define ATC_CKD_DIV1 2'h0
`define ATC_CKD_DIV2 2'h1
`define ATC_CKD_DIV4 2'h2
`define ATC_DIV2_MASK 2'h1
`define ATC_DIV4_MASK 2'h3

`endif

//--- atc_div_if.sv
// Link between the control block and the sampling clock divider
`timescale 1ns/10ps
interface atc_div_if;
    logic [1:0] sample_clock_divider;
    logic tick;
    modport ctrl (output sample_clock_divider, input tick);
    modport div (input sample_clock_divider, output tick);
endinterface

//--- atc_pkg.sv
// Types shared by the timer control modules
package atc_pkg;
    typedef enum logic [1:0] {ALIGN_EDGE, ALIGN_CM1, ALIGN_CM2, ALIGN_CM3} atc_align_e;
    typedef enum logic {DIR_UP, DIR_DOWN} atc_dir_e;
endpackage

//--- atc_sample_div.sv
// Sampling clock divider producing a tick every 1, 2 or 4 kernel clocks
`timescale 1ns/10ps
`include "atc_consts.svh"
module atc_sample_div (
    input wire logic mclk,
    input wire logic rstn,
    atc_div_if.div d
);

    logic [1:0] phase_q;
    logic tick_q;
    logic [1:0] msk;

    always_comb begin
        case (d.sample_clock_divider)
            `ATC_CKD_DIV1: msk = 2'h0;
            `ATC_CKD_DIV2: msk = `ATC_DIV2_MASK;
            default: msk = `ATC_DIV4_MASK;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            phase_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            tick_q <= ((phase_q & msk) == 2'h0);
        end
    end

    assign d.tick = tick_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_div1;
        // Tick register lags the ratio and the reset by one clock
        (d.sample_clock_divider == `ATC_CKD_DIV1) [*3] |-> tick_q;
    endproperty
    a_div1: assert property (p_div1) else $error("Tick missing at ratio one");

    property p_div2;
        (d.sample_clock_divider == `ATC_CKD_DIV2) [*4] ##0 tick_q |-> !$past(tick_q, 1) && $past(tick_q, 2);
    endproperty
    a_div2: assert property (p_div2) else $error("Tick spacing wrong at ratio two");

    property p_div4;
        (d.sample_clock_divider == `ATC_CKD_DIV4) [*6] ##0 tick_q |-> $past(tick_q, 4) &&
            !$past(tick_q, 1) && !$past(tick_q, 2) && !$past(tick_q, 3);
    endproperty
    a_div4: assert property (p_div4) else $error("Tick spacing wrong at ratio four");

endmodule

//--- atc_timer_ctrl.sv
// Counter control of the advanced timer with APB registers and interrupt
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
`include "atc_consts.svh"
module atc_timer_ctrl #(
    parameter int NCH = 4,
    parameter int CW = 16
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic encoderMode,
    input wire logic encDown,
    input wire logic encStep,
    output logic irq,
    output logic sampleTick,
    output logic countDown,
    output logic updateEvt,
    output logic [CW-1:0] cntValue
);

    localparam int IW = (NCH > 1) ? $clog2(NCH) : 1;

    // ******************************
    // Decode
    // ******************************
    logic takeWr;
    logic takeRd;
    logic [IW-1:0] ccrIdx;

    function automatic logic ccrHit(input logic [7:0] a);
        ccrHit = (32'(a) >= 32'(`ATC_A_CCR0)) && (32'(a) < 32'(`ATC_A_CCR0) + 32'(4 * NCH))
            && (a[1:0] == 2'h0);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            `ATC_A_CR1, `ATC_A_EN, `ATC_A_STAT, `ATC_A_MASK,
            `ATC_A_ARR, `ATC_A_CNT, `ATC_A_CHSEL: mapped = 1'b1;
            default: mapped = ccrHit(a);
        endcase
    endfunction

    assign takeWr = psel & penable & pwrite;
    assign takeRd = psel & ~penable;
    assign ccrIdx = IW'((paddr - `ATC_A_CCR0) >> 2);

    // ******************************
    // Registers
    // ******************************
    logic [`ATC_CR1_W-1:0] cr1_q;
    logic en_q;
    logic [NCH:0] stat_q;
    logic [NCH:0] mask_q;
    logic [CW-1:0] arrPre_q;
    logic [CW-1:0] arrAct_q;
    logic [CW-1:0] cnt_q;
    logic [2*NCH-1:0] chSel_q;
    logic [CW-1:0] ccr_q [NCH];
    atc_pkg::atc_dir_e dir_q;
    logic updateEvt_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    atc_pkg::atc_align_e align;
    logic centre;
    logic dirRo;
    logic running;
    logic step;
    logic reload_preload_enable;
    logic remap;

    assign align = atc_pkg::atc_align_e'(cr1_q[`ATC_CR1_CMS_HI:`ATC_CR1_CMS_LO]);
    assign centre = (align != atc_pkg::ALIGN_EDGE);
    assign dirRo = centre | encoderMode;
    assign running = cr1_q[`ATC_CR1_CEN] & en_q;
    assign step = running & (encoderMode ? encStep : 1'b1);
    assign reload_preload_enable = cr1_q[`ATC_CR1_RELOAD_PRELOAD_ENABLE];
    assign remap = cr1_q[`ATC_CR1_REMAP];

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cr1_q <= `ATC_CR1_RST;
        end else if (takeWr && paddr == `ATC_A_CR1) begin
            cr1_q <= pwdata[`ATC_CR1_W-1:0] & `ATC_CR1_WMASK;
            if (dirRo) begin
                cr1_q[`ATC_CR1_DIR] <= cr1_q[`ATC_CR1_DIR];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            en_q <= `ATC_EN_RST;
            mask_q <= '0;
            chSel_q <= '0;
        end else if (takeWr) begin
            if (paddr == `ATC_A_EN) begin
                en_q <= pwdata[0];
            end
            if (paddr == `ATC_A_MASK) begin
                mask_q <= pwdata[NCH:0];
            end
            if (paddr == `ATC_A_CHSEL) begin
                chSel_q <= pwdata[2*NCH-1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < NCH; i++) begin
                ccr_q[i] <= '0;
            end
        end else if (takeWr && ccrHit(paddr)) begin
            ccr_q[ccrIdx] <= pwdata[CW-1:0];
        end
    end

    // ******************************
    // Counter
    // ******************************
    logic effDown;
    logic upd;
    logic [CW-1:0] cntNext;
    atc_pkg::atc_dir_e dirNext;

    always_comb begin
        if (centre) begin
            effDown = (dir_q == atc_pkg::DIR_DOWN);
        end else begin
            effDown = encoderMode ? encDown : cr1_q[`ATC_CR1_DIR];
        end
        cntNext = cnt_q;
        dirNext = effDown ? atc_pkg::DIR_DOWN : atc_pkg::DIR_UP;
        upd = 1'b0;
        if (!effDown) begin
            if (cnt_q == arrAct_q) begin
                upd = 1'b1;
                if (centre && arrAct_q != '0) begin
                    cntNext = cnt_q - CW'(1);
                    dirNext = atc_pkg::DIR_DOWN;
                end else begin
                    cntNext = '0;
                end
            end else begin
                cntNext = cnt_q + CW'(1);
            end
        end else begin
            if (cnt_q == '0) begin
                upd = 1'b1;
                if (centre && arrAct_q != '0) begin
                    cntNext = cnt_q + CW'(1);
                    dirNext = atc_pkg::DIR_UP;
                end else begin
                    cntNext = arrAct_q;
                end
            end else begin
                cntNext = cnt_q - CW'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (takeWr && paddr == `ATC_A_CNT) begin
            cnt_q <= pwdata[CW-1:0];
        end else if (step) begin
            cnt_q <= cntNext;
        end
    end

    // Direction state tracks the running count direction
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dir_q <= atc_pkg::DIR_UP;
        end else if (step || !centre) begin
            dir_q <= dirNext;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            arrPre_q <= '0;
            arrAct_q <= '0;
        end else begin
            if (takeWr && paddr == `ATC_A_ARR) begin
                arrPre_q <= pwdata[CW-1:0];
                if (!reload_preload_enable) begin
                    arrAct_q <= pwdata[CW-1:0];
                end
            end
            if (reload_preload_enable && step && upd) begin
                arrAct_q <= arrPre_q;
            end
        end
    end

    // ******************************
    // Compare flags and status
    // ******************************
    logic allow;
    logic [NCH-1:0] ccSet;
    logic [NCH:0] stClr;

    always_comb begin
        case (align)
            atc_pkg::ALIGN_EDGE: allow = 1'b1;
            atc_pkg::ALIGN_CM1: allow = effDown;
            atc_pkg::ALIGN_CM2: allow = !effDown;
            atc_pkg::ALIGN_CM3: allow = 1'b1;
            default: allow = 1'b0;
        endcase
        for (int i = 0; i < NCH; i++) begin
            ccSet[i] = step && (chSel_q[2*i +: 2] == `ATC_CH_OUT)
                && (cnt_q == ccr_q[i]) && allow;
        end
        stClr = (takeWr && paddr == `ATC_A_STAT) ? pwdata[NCH:0] : '0;
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~stClr) | {ccSet, step & upd};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            updateEvt_q <= 1'b0;
        end else begin
            updateEvt_q <= step & upd;
        end
    end

    // ******************************
    // Read path
    // ******************************
    logic [31:0] rdData;

    always_comb begin
        rdData = 32'h0;
        case (paddr)
            `ATC_A_CR1: begin
                rdData = 32'(cr1_q);
                if (dirRo) begin
                    rdData[`ATC_CR1_DIR] = (dir_q == atc_pkg::DIR_DOWN);
                end
            end
            `ATC_A_EN: rdData = 32'(en_q);
            `ATC_A_STAT: rdData = 32'(stat_q);
            `ATC_A_MASK: rdData = 32'(mask_q);
            `ATC_A_ARR: rdData = 32'(arrPre_q);
            `ATC_A_CNT: begin
                rdData = 32'(cnt_q);
                rdData[`ATC_CNT_FLAG] = remap & stat_q[`ATC_ST_UPD];
            end
            `ATC_A_CHSEL: rdData = 32'(chSel_q);
            default: begin
                if (ccrHit(paddr)) begin
                    rdData = 32'(ccr_q[ccrIdx]);
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (takeRd) begin
            prdata_q <= rdData;
            pslverr_q <= !mapped(paddr);
        end
    end

    // ******************************
    // Sampling clock
    // ******************************
    atc_div_if divLink ();

    assign divLink.sample_clock_divider = cr1_q[`ATC_CR1_CKD_HI:`ATC_CR1_CKD_LO];

    atc_sample_div uDiv (
        .mclk(mclk),
        .rstn(rstn),
        .d(divLink)
    );

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q;
    assign irq = |(stat_q & mask_q);
    assign sampleTick = divLink.tick;
    assign countDown = (dir_q == atc_pkg::DIR_DOWN);
    assign updateEvt = updateEvt_q;
    assign cntValue = cnt_q;

    // ******************************
    // Checks
    // ******************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic cntWr;
    logic arrWr;
    assign cntWr = takeWr && paddr == `ATC_A_CNT;
    assign arrWr = takeWr && paddr == `ATC_A_ARR;

    property p_arr_direct;
        arrWr && !reload_preload_enable |=> arrAct_q == $past(pwdata[CW-1:0]);
    endproperty
    a_arr_direct: assert property (p_arr_direct) else $error("Direct reload not applied");

    property p_arr_hold;
        arrWr && reload_preload_enable && !(step && upd) |=> $stable(arrAct_q);
    endproperty
    a_arr_hold: assert property (p_arr_hold) else $error("Buffered reload leaked");

    property p_arr_load;
        reload_preload_enable && step && upd && !arrWr |=> arrAct_q == $past(arrPre_q);
    endproperty
    a_arr_load: assert property (p_arr_load) else $error("Buffered reload not loaded");

    property p_edge_dir;
        !centre && !encoderMode && step && !cntWr && cnt_q != '0 && cnt_q != arrAct_q
            |=> cnt_q == ($past(cr1_q[`ATC_CR1_DIR]) ? $past(cnt_q) - CW'(1)
            : $past(cnt_q) + CW'(1));
    endproperty
    a_edge_dir: assert property (p_edge_dir) else $error("Edge count direction wrong");

    property p_centre_turn;
        centre && step && !cntWr && !effDown && cnt_q == arrAct_q && arrAct_q != '0
            |=> countDown ##1 (!step || cntWr || cnt_q == '0 || countDown);
    endproperty
    a_centre_turn: assert property (p_centre_turn) else $error("No turn at top");

    property p_cm1_down;
        $rose(stat_q[1]) && $past(align) == atc_pkg::ALIGN_CM1 |-> $past(effDown);
    endproperty
    a_cm1_down: assert property (p_cm1_down) else $error("Mode 1 flag while up");

    property p_cm2_up;
        $rose(stat_q[1]) && $past(align) == atc_pkg::ALIGN_CM2 |-> !$past(effDown);
    endproperty
    a_cm2_up: assert property (p_cm2_up) else $error("Mode 2 flag while down");

    property p_cm3_both;
        align == atc_pkg::ALIGN_CM3 && step && chSel_q[1:0] == `ATC_CH_OUT
            && cnt_q == ccr_q[0] |=> stat_q[1];
    endproperty
    a_cm3_both: assert property (p_cm3_both) else $error("Mode 3 flag missed");

    property p_out_only;
        $rose(stat_q[1]) |-> $past(chSel_q[1:0]) == `ATC_CH_OUT;
    endproperty
    a_out_only: assert property (p_out_only) else $error("Flag on input channel");

    property p_dir_ro;
        takeWr && paddr == `ATC_A_CR1 && dirRo |=> $stable(cr1_q[`ATC_CR1_DIR]);
    endproperty
    a_dir_ro: assert property (p_dir_ro) else $error("Read-only direction changed");

    property p_remap;
        takeRd && paddr == `ATC_A_CNT |=> prdata[`ATC_CNT_FLAG] ==
            ($past(remap) && $past(stat_q[`ATC_ST_UPD]));
    endproperty
    a_remap: assert property (p_remap) else $error("Bit 31 copy wrong");

    property p_dir_show;
        centre && step && !cntWr && effDown && cnt_q == '0 && arrAct_q != '0 |=> !countDown;
    endproperty
    a_dir_show: assert property (p_dir_show) else $error("Direction not shown");

    c_centre_up_down: cover property (centre && countDown ##1 centre && !countDown);
    c_buffered_load: cover property (reload_preload_enable && step && upd);
    c_irq: cover property ($rose(irq));
    c_set_clear: cover property (|(stClr & {ccSet, step & upd}));

endmodule

//--- test_atc_timer_ctrl.sv
// Self-checking testbench of the timer counter control block
`timescale 1ns/10ps
`include "atc_consts.svh"
module test_atc_timer_ctrl;
    // **********
    // Signals
    // **********
    logic mclk, rstn, psel, penable, pwrite, encoderMode, encDown, encStep;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq, sampleTick, countDown, updateEvt, err;
    logic [15:0] cntValue;
    int failures;
    int samples_checked;
    localparam logic [7:0] REGS [7] = '{`ATC_A_CR1, `ATC_A_EN, `ATC_A_STAT, `ATC_A_MASK,
        `ATC_A_ARR, `ATC_A_CNT, `ATC_A_CHSEL};

    atc_timer_ctrl i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .encoderMode(encoderMode), .encDown(encDown), .encStep(encStep),
        .irq(irq), .sampleTick(sampleTick), .countDown(countDown), .updateEvt(updateEvt),
        .cntValue(cntValue));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // **********
    // Tasks
    // **********
    task automatic finish_test();
        $display("Counts: %0d checked, %0d failed", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rck(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        check(rd, e);
    endtask

    task automatic done(input string s);
        $display("Test %0s finished", s);
    endtask

    function automatic logic [15:0] nxt(logic [15:0] c, logic [15:0] a, logic dn);
        if (dn) begin
            return (c == 16'h0) ? a : c - 16'h1;
        end
        return (c == a) ? 16'h0 : c + 16'h1;
    endfunction

    // Edge-mode step check; p becomes active once the counter wraps
    task automatic mon(input int n, input logic dn, input logic [15:0] a, input logic [15:0] p);
        logic [15:0] prev;
        @(posedge mclk);
        #1 prev = cntValue;
        repeat (n) begin
            @(posedge mclk);
            #1;
            check(cntValue, nxt(prev, a, dn));
            check(countDown, dn);
            check(updateEvt, prev == (dn ? 16'h0 : a));
            if (prev == (dn ? 16'h0 : a)) a = p;
            prev = cntValue;
        end
    endtask

    task automatic mon_c(input int n, input logic [15:0] a);
        logic [15:0] prev;
        logic [1:0] seen;
        seen = 2'b00;
        @(posedge mclk);
        #1 prev = cntValue;
        repeat (n) begin
            @(posedge mclk);
            #1;
            check(cntValue == prev + 16'h1 || cntValue + 16'h1 == prev, 1'b1);
            check(cntValue <= a, 1'b1);
            seen = seen | (countDown ? 2'b10 : 2'b01);
            prev = cntValue;
        end
        check(seen, 2'b11);
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        finish_test();
    end

    // **********
    // Sequence
    // **********
    initial begin
        logic [31:0] x;
        logic [15:0] a;
        logic [15:0] e;
        logic s, d, pd, v;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        encoderMode = 1'b0;
        encDown = 1'b0;
        encStep = 1'b0;
        failures = 0;
        samples_checked = 0;
        void'($urandom(46));
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        check({irq, countDown, updateEvt, cntValue}, 32'h0);
        foreach (REGS[i]) rck(REGS[i], 32'h0);
        apb(8'h1c, 1'b0, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(8'h02, 1'b1, 32'h1);
        check(err, 1'b1);
        done("reset");
        repeat (8) begin
            x = ($urandom & 32'h89f) | (($urandom % 3) << 8);
            wr(`ATC_A_CR1, x);
            rck(`ATC_A_CR1, x);
            x = $urandom & 32'hffff;
            wr(`ATC_A_ARR, x);
            rck(`ATC_A_ARR, x);
        end
        done("registers");
        for (int c = 0; c < 3; c++) begin
            wr(`ATC_A_CR1, 32'(c << 8));
            repeat (4) @(posedge mclk);
            x = 0;
            repeat (40) begin
                @(posedge mclk);
                #1 x = x + sampleTick;
            end
            check(x, 40 >> c);
        end
        done("sample tick");
        for (int k = 0; k < 2; k++) begin
            a = 16'(1 + $urandom % 6);
            wr(`ATC_A_CR1, 32'h0);
            wr(`ATC_A_EN, 32'h0);
            wr(`ATC_A_ARR, {16'h0, a});
            wr(`ATC_A_CNT, $urandom % (a + 1));
            wr(`ATC_A_CR1, 32'(k << 4) | 32'h1);
            wr(`ATC_A_EN, 32'h1);
            mon(20, k[0], a, a);
        end
        wr(`ATC_A_EN, 32'h0);
        wr(`ATC_A_CR1, 32'h0);
        wr(`ATC_A_ARR, 32'h4);
        wr(`ATC_A_CNT, 32'h0);
        wr(`ATC_A_CR1, 32'h81);
        wr(`ATC_A_ARR, 32'h7);
        rck(`ATC_A_ARR, 32'h7);
        wr(`ATC_A_EN, 32'h1);
        mon(16, 1'b0, 16'h4, 16'h7);
        wr(`ATC_A_EN, 32'h0);
        done("edge counting");
        wr(`ATC_A_MASK, 32'h1);
        apb(`ATC_A_STAT, 1'b0, 32'h0);
        check({irq, rd[0]}, 2'b11);
        wr(`ATC_A_CR1, 32'h800);
        apb(`ATC_A_CNT, 1'b0, 32'h0);
        check(rd[31], 1'b1);
        wr(`ATC_A_CR1, 32'h0);
        apb(`ATC_A_CNT, 1'b0, 32'h0);
        check(rd[31], 1'b0);
        wr(`ATC_A_MASK, 32'h0);
        check(irq, 1'b0);
        wr(`ATC_A_MASK, 32'h1);
        wr(`ATC_A_STAT, 32'h1f);
        rck(`ATC_A_STAT, 32'h0);
        check(irq, 1'b0);
        done("interrupt");
        wr(`ATC_A_ARR, 32'h6);
        wr(`ATC_A_CNT, 32'h0);
        wr(`ATC_A_CR1, 32'h60);
        wr(`ATC_A_CR1, 32'h61);
        wr(`ATC_A_EN, 32'h1);
        mon_c(30, 16'h6);
        wr(`ATC_A_EN, 32'h0);
        v = countDown;
        wr(`ATC_A_CR1, {25'h0, 2'b11, ~v, 4'h1});
        apb(`ATC_A_CR1, 1'b0, 32'h0);
        check({countDown, rd[4]}, {v, v});
        done("centre counting");
        wr(`ATC_A_ARR, 32'd100);
        wr(`ATC_A_CHSEL, 32'h50);
        for (int c = 0; c < 4; c++) wr(8'(`ATC_A_CCR0 + 4 * c), c[0] ? 32'd97 : 32'd2);
        for (int m = 1; m < 4; m++) begin
            wr(`ATC_A_CR1, 32'h0);
            wr(`ATC_A_CNT, 32'h0);
            wr(`ATC_A_STAT, 32'h1f);
            wr(`ATC_A_CR1, 32'(m << 5));
            wr(`ATC_A_CR1, 32'(m << 5) | 32'h1);
            wr(`ATC_A_EN, 32'h1);
            repeat (6) @(posedge mclk);
            wr(`ATC_A_EN, 32'h0);
            wr(`ATC_A_CNT, 32'd100);
            wr(`ATC_A_EN, 32'h1);
            repeat (2) @(posedge mclk);
            wr(`ATC_A_EN, 32'h0);
            apb(`ATC_A_STAT, 1'b0, 32'h0);
            check(rd[4:1], {2'b00, m != 2, m != 1});
        end
        done("compare flags");
        wr(`ATC_A_CR1, 32'h0);
        wr(`ATC_A_ARR, 32'h7);
        wr(`ATC_A_CNT, 32'h3);
        wr(`ATC_A_CR1, 32'h1);
        encoderMode <= 1'b1;
        wr(`ATC_A_EN, 32'h1);
        e = 16'h3;
        pd = 1'b0;
        repeat (24) begin
            @(posedge mclk);
            s = 1'($urandom % 2);
            d = 1'($urandom % 2);
            encStep <= s;
            encDown <= d;
            #1;
            check(cntValue, e);
            check(countDown, pd);
            if (s) e = nxt(e, 16'h7, d);
            pd = d;
        end
        done("encoder");
        finish_test();
    end
endmodule
